// ---- verif/cogt_driver_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// power stage gate drivers
// ----------------------------------------
module cogt_driver_model
(
  input  wire  clk,              // clock
  input  wire  primaryOut,       // high side command
  input  wire  complementaryOut, // low side command
  output logic hiGate,           // high side gate
  output logic loGate            // low side gate
);
  // one clock of propagation; a real stage is never instant
  always @(posedge clk)
  begin
    hiGate <= primaryOut;
    loGate <= complementaryOut;
  end
endmodule

// ---- verif/cogt_timing_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// apb answer and readback checks
// ----------------------------------------
module cogt_timing_assertions
(
  input wire        clk,              // clock
  input wire        nrst,             // sync reset, active low
  input wire        psel,             // apb select
  input wire        penable,          // apb access phase
  input wire        pwrite,           // apb direction
  input wire [11:0] paddr,            // apb byte address
  input wire [31:0] prdata,           // apb read data
  input wire        pready,           // apb ready
  input wire        pslverr,          // apb error
  input wire        primaryOut,       // primary wave
  input wire        complementaryOut  // complementary wave
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // a setup cycle is answered in the very next cycle
  setup_answer_a: assert property (psel && !penable ##1 psel && penable |-> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
    else $error("ready without setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  idle_zero_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero when idle");
  count_top_a: assert property (pready && !pwrite && paddr <= 12'h014 |-> prdata[31:6] == 26'h0)
    else $error("count upper bits not zero");
  // unmapped places answer with an error and no data
  unmapped_err_a: assert property (pready && (paddr > 12'h030 || paddr[1:0] != 2'b00) |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (pready && paddr <= 12'h030 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");

  cover property (pready && pwrite);
  cover property (pready && pslverr);
  cover property ($rose(primaryOut));
  cover property ($rose(complementaryOut));
endmodule

bind cogt_timing cogt_timing_assertions chk
(
  .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .primaryOut(primaryOut), .complementaryOut(complementaryOut)
);

// ---- verif/cogt_timing_test.sv ----
`timescale 1ns/1ps
module cogt_timing_test;
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [6:0]  risingSource;
  logic [6:0]  fallingSource;
  logic        primaryOut;
  logic        complementaryOut;
  logic        hiGate;
  logic        loGate;
  logic [31:0] rdat;
  logic        rerr;
  int          numErrors;
  int          totalChecks;
  int          br;
  int          bf;
  int          n;
  int          i;

  cogt_timing dut
  (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .risingSource(risingSource), .fallingSource(fallingSource),
    .primaryOut(primaryOut), .complementaryOut(complementaryOut)
  );

  cogt_driver_model drv
  (
    .clk(clk), .primaryOut(primaryOut), .complementaryOut(complementaryOut),
    .hiGate(hiGate), .loGate(loGate)
  );

  // ----------------------------------------
  // clock and helpers
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task conclude;
    begin
      $display("checks %0d mismatches %0d", totalChecks, numErrors);
      if (numErrors == 0 && totalChecks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task check(input string w, input logic [31:0] e, input logic [31:0] g);
    begin
      totalChecks++;
      if (g !== e)
      begin
        numErrors++;
        $display("ERROR %s expected %h seen %h", w, e, g);
      end
    end
  endtask

  // one apb transfer, then an idle cycle so no signal is driven twice at one edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
        @(posedge clk);
        k++;
      end
      while (pready !== 1'b1 && k < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50)
      begin
        numErrors++;
        conclude();
      end
      @(posedge clk);
    end
  endtask

  // packed as {phf, phr, blkf, blkr, fdb, rdb}
  task cfg(input logic [35:0] v);
    begin
      for (int k = 0; k < 6; k++)
        apb(1'b1, 12'(k * 4), {26'h0, v[k*6 +: 6]});
    end
  endtask

  // source 0 fires, count cycles until the gate answers
  task ev(input logic rise, output int c);
    begin
      if (rise)
        risingSource <= 7'h01;
      else
        fallingSource <= 7'h7E;
      c = 0;
      do
      begin
        @(posedge clk);
        c++;
      end
      while ((rise ? hiGate : loGate) !== 1'b1 && c < 300);
      if (c >= 300)
      begin
        numErrors++;
        conclude();
      end
      risingSource <= 7'h00;
      fallingSource <= 7'h7F;
      repeat (10) @(posedge clk);
    end
  endtask

  // short opposing pulse, long enough to pass the input filter
  task pulse(input logic rise);
    begin
      if (rise)
        risingSource <= 7'h01;
      else
        fallingSource <= 7'h7E;
      repeat (5) @(posedge clk);
      risingSource <= 7'h00;
      fallingSource <= 7'h7F;
      repeat (40) @(posedge clk);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    risingSource = 7'h00;
    fallingSource = 7'h7F;
    numErrors = 0;
    totalChecks = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // top two bits written as ones must vanish; values survive a reset
    for (i = 0; i < 6; i++)
      apb(1'b1, 12'(i * 4), 32'hFFFFFFE8 + i);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 6; i++)
    begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check("count reg", 32'(40 + i), rdat);
    end
    apb(1'b0, 12'h040, 32'h0);
    check("unmapped err", 32'h1, rerr);
    check("unmapped data", 32'h0, rdat);
    $display("register test done");
    // source 0 enabled in edge mode both ways, generator on
    cfg(36'h0);
    for (i = 7; i < 11; i++)
      apb(1'b1, 12'(i * 4), 32'h1);
    apb(1'b1, 12'h018, 32'h0);
    apb(1'b1, 12'h02C, 32'h80);
    ev(1'b1, br);
    ev(1'b0, bf);
    check("zero count rise", 32'h1, br <= 9);
    cfg({6'd7, 6'd5, 24'd0});
    ev(1'b1, n);
    check("rise phase", br + 5, n);
    ev(1'b0, n);
    check("fall phase", bf + 7, n);
    $display("phase test done");
    cfg({24'd0, 6'd6, 6'd4});
    ev(1'b1, n);
    check("rise deadband", br + 4, n);
    ev(1'b0, n);
    check("fall deadband", bf + 6, n);
    // chain ticks every two clocks; tick phase allows one clock of slack
    apb(1'b1, 12'h018, 32'hC0);
    ev(1'b1, n);
    check("chain rise", 32'h1, n >= br + 7 && n <= br + 9);
    ev(1'b0, n);
    check("chain fall", 32'h1, n >= bf + 11 && n <= bf + 13);
    apb(1'b1, 12'h018, 32'h0);
    $display("dead-band test done");
    // level mode ignores a long falling phase delay
    cfg({6'd20, 30'd0});
    apb(1'b1, 12'h028, 32'h0);
    ev(1'b1, n);
    ev(1'b0, n);
    check("level fall", 32'h1, n <= bf + 1);
    apb(1'b1, 12'h028, 32'h1);
    cfg({12'd0, 6'd30, 6'd30, 12'd0});
    ev(1'b1, n);
    pulse(1'b0);
    check("rise blanking", 32'h1, hiGate);
    ev(1'b0, n);
    pulse(1'b1);
    check("fall blanking", 32'h1, loGate);
    ev(1'b1, n);
    $display("blanking test done");
    conclude();
  end
endmodule

// ---- verilog/cogt_delay_cnt.v ----
`timescale 1ns/1ps
`include "cogt_regs.vh"
module cogt_delay_cnt
(
  input  wire                   clk,      // system clock
  input  wire                   nrst,     // sync reset, active low
  input  wire                   tick,     // count enable pulse
  input  wire                   start,    // restart interval
  input  wire [`COGT_CNT_W-1:0] count,    // interval length in ticks
  output wire                   busy,     // interval running
  output wire                   done      // end-of-interval pulse
);

  reg [`COGT_CNT_W-1:0] remain_reg;
  reg                   busy_reg;
  wire                  zeroStart;
  wire                  lastTick;

  // ----------------------------------------------------------------
  // down counter
  // ----------------------------------------------------------------
  // a zero count finishes in the start cycle itself, so no delay
  assign zeroStart = start & (count == {`COGT_CNT_W{1'b0}});
  // the last tick ends the interval at once, so n ticks cost exactly n
  assign lastTick  = busy_reg & tick & ~start & (remain_reg == 6'h01);
  assign busy      = busy_reg;
  assign done      = zeroStart | lastTick;

  // restart wins over a running interval so the latest event rules
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      remain_reg <= {`COGT_CNT_W{1'b0}};
      busy_reg   <= 1'b0;
    end
    else if (start)
    begin
      remain_reg <= count;
      busy_reg   <= ~zeroStart;
    end
    else if (busy_reg && tick)
    begin
      remain_reg <= remain_reg - 6'h01;
      busy_reg   <= (remain_reg != 6'h01);
    end
  end

endmodule

// ---- verilog/cogt_regs.vh ----
// Functional notes
// - rising dead-band select 0: count clock periods
// - rising dead-band select 1: count chain periods
// - falling dead-band select 0: count clock periods
// - falling dead-band select 1: count chain periods
// - rising event blanks falling inputs for count
// - falling event blanks rising inputs for count
// - rising edge event delayed by phase count
// - falling edge event delayed by phase count
// - count bits 7-6 read zero, ignore writes
// - counts read-write, undefined at power-on, unreset
// - falling edge-mode source waits falling phase delay
// - falling level-mode source acts at once
`ifndef COGT_REGS_VH
`define COGT_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define COGT_OFS_RDB     12'h000
`define COGT_OFS_FDB     12'h004
`define COGT_OFS_BLKR    12'h008
`define COGT_OFS_BLKF    12'h00C
`define COGT_OFS_PHR     12'h010
`define COGT_OFS_PHF     12'h014
`define COGT_OFS_CTRL1   12'h018
`define COGT_OFS_RIS     12'h01C
`define COGT_OFS_RSIM    12'h020
`define COGT_OFS_FIS     12'h024
`define COGT_OFS_FSIM    12'h028
`define COGT_OFS_CTRL0   12'h02C
`define COGT_OFS_STAT    12'h030

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define COGT_CNT_W       6
`define COGT_SRC_W       7
`define COGT_RDBS_BIT    7
`define COGT_FDBS_BIT    6
`define COGT_EN_BIT      7
`define COGT_ST_STATE    0
`define COGT_ST_PRI      1
`define COGT_ST_CMP      2
`define COGT_ST_BLKR     3
`define COGT_ST_BLKF     4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define COGT_RST_CTRL    8'h00
`define COGT_RST_SRC     7'h00

// ----------------------------------------------------------------
// timing: delay chain element period, in clock cycles
// ----------------------------------------------------------------
`define COGT_CHAIN_NS    20
`define COGT_CLK_NS      10
`define COGT_CHAIN_DIV   (`COGT_CHAIN_NS / `COGT_CLK_NS)

`endif

// ---- verilog/cogt_timing.v ----
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cogt_regs.vh"
module cogt_timing
(
  input  wire                   clk,              // 100 MHz system clock
  input  wire                   nrst,             // sync reset, active low
  input  wire                   psel,             // apb select
  input  wire                   penable,          // apb access phase
  input  wire                   pwrite,           // apb write
  input  wire [11:0]            paddr,            // apb byte address
  input  wire [31:0]            pwdata,           // apb write data
  output wire [31:0]            prdata,           // apb read data
  output wire                   pready,           // apb ready
  output wire                   pslverr,          // apb error, unmapped
  input  wire [`COGT_SRC_W-1:0] risingSource,     // rising event sources
  input  wire [`COGT_SRC_W-1:0] fallingSource,    // falling event sources
  output wire                   primaryOut,       // primary waveform
  output wire                   complementaryOut  // complementary waveform
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [`COGT_CNT_W-1:0] risingDeadbandValue_reg;
  reg [`COGT_CNT_W-1:0] fallingDeadbandValue_reg;
  reg [`COGT_CNT_W-1:0] risingBlankingValue_reg;
  reg [`COGT_CNT_W-1:0] fallingBlankingValue_reg;
  reg [`COGT_CNT_W-1:0] risingPhaseValue_reg;
  reg [`COGT_CNT_W-1:0] fallingPhaseValue_reg;
  reg                   risingDeadbandSourceSelect_reg;
  reg                   fallingDeadbandSourceSelect_reg;
  reg                   generatorEnable_reg;
  reg [`COGT_SRC_W-1:0] risingSourceEnable_reg;
  reg [`COGT_SRC_W-1:0] risingSourceInputMode_reg;
  reg [`COGT_SRC_W-1:0] fallingSourceEnable_reg;
  reg [`COGT_SRC_W-1:0] fallingSourceInputMode_reg;

  reg [31:0]            prdata_reg;
  reg                   pready_reg;
  reg                   pslverr_reg;

  reg [`COGT_SRC_W-1:0] riseS1_reg;
  reg [`COGT_SRC_W-1:0] riseS2_reg;
  reg [`COGT_SRC_W-1:0] riseS3_reg;
  reg [`COGT_SRC_W-1:0] riseClean_reg;
  reg [`COGT_SRC_W-1:0] riseCleanPrev_reg;
  reg [`COGT_SRC_W-1:0] fallS1_reg;
  reg [`COGT_SRC_W-1:0] fallS2_reg;
  reg [`COGT_SRC_W-1:0] fallS3_reg;
  reg [`COGT_SRC_W-1:0] fallClean_reg;
  reg [`COGT_SRC_W-1:0] fallCleanPrev_reg;

  reg [7:0]             chainDiv_reg;
  reg                   chainTick_reg;
  reg                   state_reg;
  reg                   primary_reg;
  reg                   complementary_reg;

  reg [31:0]            readData;
  reg                   readHit;

  wire                  wrStrobe;
  wire                  setupCycle;
  wire [`COGT_SRC_W-1:0] riseEdge;
  wire [`COGT_SRC_W-1:0] fallEdge;
  wire                  riseEdgeReq;
  wire                  riseLevelReq;
  wire                  fallEdgeReq;
  wire                  fallLevelReq;
  wire                  risePhaseDone;
  wire                  fallPhaseDone;
  wire                  riseEvent;
  wire                  fallEvent;
  wire                  riseTake;
  wire                  fallTake;
  wire                  blankRiseBusy;
  wire                  blankFallBusy;
  wire                  riseDbTick;
  wire                  fallDbTick;
  wire                  riseDbDone;
  wire                  fallDbDone;
  wire                  riseDbBusy;
  wire                  fallDbBusy;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // no wait state: pready rises in the first access cycle
  assign setupCycle = psel & ~penable;
  assign wrStrobe   = psel & penable & pready_reg & pwrite;
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;

  // read mux; upper bits of every count read zero
  always @*
  begin
    readData = 32'h00000000;
    readHit  = 1'b1;
    case (paddr)
      `COGT_OFS_RDB:   readData[`COGT_CNT_W-1:0] = risingDeadbandValue_reg;
      `COGT_OFS_FDB:   readData[`COGT_CNT_W-1:0] = fallingDeadbandValue_reg;
      `COGT_OFS_BLKR:  readData[`COGT_CNT_W-1:0] = risingBlankingValue_reg;
      `COGT_OFS_BLKF:  readData[`COGT_CNT_W-1:0] = fallingBlankingValue_reg;
      `COGT_OFS_PHR:   readData[`COGT_CNT_W-1:0] = risingPhaseValue_reg;
      `COGT_OFS_PHF:   readData[`COGT_CNT_W-1:0] = fallingPhaseValue_reg;
      `COGT_OFS_CTRL1:
      begin
        readData[`COGT_RDBS_BIT] = risingDeadbandSourceSelect_reg;
        readData[`COGT_FDBS_BIT] = fallingDeadbandSourceSelect_reg;
      end
      `COGT_OFS_RIS:   readData[`COGT_SRC_W-1:0] = risingSourceEnable_reg;
      `COGT_OFS_RSIM:  readData[`COGT_SRC_W-1:0] = risingSourceInputMode_reg;
      `COGT_OFS_FIS:   readData[`COGT_SRC_W-1:0] = fallingSourceEnable_reg;
      `COGT_OFS_FSIM:  readData[`COGT_SRC_W-1:0] = fallingSourceInputMode_reg;
      `COGT_OFS_CTRL0: readData[`COGT_EN_BIT] = generatorEnable_reg;
      `COGT_OFS_STAT:
      begin
        readData[`COGT_ST_STATE] = state_reg;
        readData[`COGT_ST_PRI]   = primary_reg;
        readData[`COGT_ST_CMP]   = complementary_reg;
        readData[`COGT_ST_BLKR]  = blankFallBusy;
        readData[`COGT_ST_BLKF]  = blankRiseBusy;
      end
      default:         readHit = 1'b0;
    endcase
  end

  // answer is prepared in the setup cycle, so outputs stay registered
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= setupCycle;
      pslverr_reg <= setupCycle & ~readHit;
      if (setupCycle && !pwrite)
      begin
        prdata_reg <= readData;
      end
      else
      begin
        prdata_reg <= 32'h00000000;
      end
    end
  end

  // timing counts have no reset: unknown at power-up, kept otherwise
  always @(posedge clk)
  begin
    if (wrStrobe)
    begin
      case (paddr)
        `COGT_OFS_RDB:  risingDeadbandValue_reg  <= pwdata[`COGT_CNT_W-1:0];
        `COGT_OFS_FDB:  fallingDeadbandValue_reg <= pwdata[`COGT_CNT_W-1:0];
        `COGT_OFS_BLKR: risingBlankingValue_reg  <= pwdata[`COGT_CNT_W-1:0];
        `COGT_OFS_BLKF: fallingBlankingValue_reg <= pwdata[`COGT_CNT_W-1:0];
        `COGT_OFS_PHR:  risingPhaseValue_reg     <= pwdata[`COGT_CNT_W-1:0];
        `COGT_OFS_PHF:  fallingPhaseValue_reg    <= pwdata[`COGT_CNT_W-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // control and source selection registers
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      risingDeadbandSourceSelect_reg  <= 1'b0;
      fallingDeadbandSourceSelect_reg <= 1'b0;
      generatorEnable_reg             <= 1'b0;
      risingSourceEnable_reg          <= `COGT_RST_SRC;
      risingSourceInputMode_reg       <= `COGT_RST_SRC;
      fallingSourceEnable_reg         <= `COGT_RST_SRC;
      fallingSourceInputMode_reg      <= `COGT_RST_SRC;
    end
    else if (wrStrobe)
    begin
      case (paddr)
        `COGT_OFS_CTRL1:
        begin
          risingDeadbandSourceSelect_reg  <= pwdata[`COGT_RDBS_BIT];
          fallingDeadbandSourceSelect_reg <= pwdata[`COGT_FDBS_BIT];
        end
        `COGT_OFS_RIS:   risingSourceEnable_reg     <= pwdata[`COGT_SRC_W-1:0];
        `COGT_OFS_RSIM:  risingSourceInputMode_reg  <= pwdata[`COGT_SRC_W-1:0];
        `COGT_OFS_FIS:   fallingSourceEnable_reg    <= pwdata[`COGT_SRC_W-1:0];
        `COGT_OFS_FSIM:  fallingSourceInputMode_reg <= pwdata[`COGT_SRC_W-1:0];
        `COGT_OFS_CTRL0: generatorEnable_reg        <= pwdata[`COGT_EN_BIT];
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // source synchronisers and edge detection
  // ----------------------------------------------------------------
  // three stages; a level is believed once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `COGT_SRC_W; gi = gi + 1)
    begin : gSync
      always @(posedge clk)
      begin
        if (!nrst)
        begin
          riseS1_reg[gi]        <= 1'b0;
          riseS2_reg[gi]        <= 1'b0;
          riseS3_reg[gi]        <= 1'b0;
          riseClean_reg[gi]     <= 1'b0;
          riseCleanPrev_reg[gi] <= 1'b0;
          fallS1_reg[gi]        <= 1'b1;
          fallS2_reg[gi]        <= 1'b1;
          fallS3_reg[gi]        <= 1'b1;
          fallClean_reg[gi]     <= 1'b1;
          fallCleanPrev_reg[gi] <= 1'b1;
        end
        else
        begin
          riseS1_reg[gi]        <= risingSource[gi];
          riseS2_reg[gi]        <= riseS1_reg[gi];
          riseS3_reg[gi]        <= riseS2_reg[gi];
          riseCleanPrev_reg[gi] <= riseClean_reg[gi];
          fallS1_reg[gi]        <= fallingSource[gi];
          fallS2_reg[gi]        <= fallS1_reg[gi];
          fallS3_reg[gi]        <= fallS2_reg[gi];
          fallCleanPrev_reg[gi] <= fallClean_reg[gi];
          if (riseS2_reg[gi] == riseS3_reg[gi])
          begin
            riseClean_reg[gi] <= riseS3_reg[gi];
          end
          if (fallS2_reg[gi] == fallS3_reg[gi])
          begin
            fallClean_reg[gi] <= fallS3_reg[gi];
          end
        end
      end
    end
  endgenerate

  assign riseEdge = riseClean_reg & ~riseCleanPrev_reg;
  assign fallEdge = ~fallClean_reg & fallCleanPrev_reg;

  // ----------------------------------------------------------------
  // event requests with blanking
  // ----------------------------------------------------------------
  // blanking masks inputs, so an edge seen while blanked is dropped
  assign riseEdgeReq  = ~blankRiseBusy &
                        (|(riseEdge & risingSourceEnable_reg & risingSourceInputMode_reg));
  assign riseLevelReq = ~blankRiseBusy &
                        (|(riseClean_reg & risingSourceEnable_reg & ~risingSourceInputMode_reg));
  assign fallEdgeReq  = ~blankFallBusy &
                        (|(fallEdge & fallingSourceEnable_reg & fallingSourceInputMode_reg));
  assign fallLevelReq = ~blankFallBusy &
                        (|(~fallClean_reg & fallingSourceEnable_reg & ~fallingSourceInputMode_reg));

  // ----------------------------------------------------------------
  // phase delay
  // ----------------------------------------------------------------
  cogt_delay_cnt uRisePhase
  (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (1'b1),
    .start (riseEdgeReq & generatorEnable_reg),
    .count (risingPhaseValue_reg),
    .busy  (),
    .done  (risePhaseDone)
  );

  cogt_delay_cnt uFallPhase
  (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (1'b1),
    .start (fallEdgeReq & generatorEnable_reg),
    .count (fallingPhaseValue_reg),
    .busy  (),
    .done  (fallPhaseDone)
  );

  // level requests skip the phase counter entirely
  assign riseEvent = generatorEnable_reg & (risePhaseDone | riseLevelReq);
  assign fallEvent = generatorEnable_reg & (fallPhaseDone | fallLevelReq);

  // only a change of state starts dead-band and blanking, so a held
  // level does not retrigger them; falling wins a tie to stay off
  assign fallTake = fallEvent & state_reg;
  assign riseTake = riseEvent & ~state_reg & ~fallEvent;

  // ----------------------------------------------------------------
  // blanking counters
  // ----------------------------------------------------------------
  cogt_delay_cnt uBlankFall
  (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (1'b1),
    .start (riseTake),
    .count (risingBlankingValue_reg),
    .busy  (blankFallBusy),
    .done  ()
  );

  cogt_delay_cnt uBlankRise
  (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (1'b1),
    .start (fallTake),
    .count (fallingBlankingValue_reg),
    .busy  (blankRiseBusy),
    .done  ()
  );

  // ----------------------------------------------------------------
  // delay chain model
  // ----------------------------------------------------------------
  // the analog chain is stood in for by a divider pulse; its element
  // period is only as fine as one clock cycle
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      chainDiv_reg  <= 8'h00;
      chainTick_reg <= 1'b0;
    end
    else if (chainDiv_reg >= (`COGT_CHAIN_DIV - 1))
    begin
      chainDiv_reg  <= 8'h00;
      chainTick_reg <= 1'b1;
    end
    else
    begin
      chainDiv_reg  <= chainDiv_reg + 8'h01;
      chainTick_reg <= 1'b0;
    end
  end

  assign riseDbTick = risingDeadbandSourceSelect_reg ? chainTick_reg : 1'b1;
  assign fallDbTick = fallingDeadbandSourceSelect_reg ? chainTick_reg : 1'b1;

  // ----------------------------------------------------------------
  // dead-band counters
  // ----------------------------------------------------------------
  cogt_delay_cnt uRiseDb
  (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (riseDbTick),
    .start (riseTake),
    .count (risingDeadbandValue_reg),
    .busy  (riseDbBusy),
    .done  (riseDbDone)
  );

  cogt_delay_cnt uFallDb
  (
    .clk   (clk),
    .nrst  (nrst),
    .tick  (fallDbTick),
    .start (fallTake),
    .count (fallingDeadbandValue_reg),
    .busy  (fallDbBusy),
    .done  (fallDbDone)
  );

  // ----------------------------------------------------------------
  // waveform state and outputs
  // ----------------------------------------------------------------
  // each output switches off at once and on only after its dead-band
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      state_reg         <= 1'b0;
      primary_reg       <= 1'b0;
      complementary_reg <= 1'b0;
    end
    else if (!generatorEnable_reg)
    begin
      state_reg         <= 1'b0;
      primary_reg       <= 1'b0;
      complementary_reg <= 1'b0;
    end
    else
    begin
      if (fallTake)
      begin
        state_reg   <= 1'b0;
        primary_reg <= 1'b0;
      end
      else if (riseTake)
      begin
        state_reg         <= 1'b1;
        complementary_reg <= 1'b0;
      end
      if (state_reg && riseDbDone && !fallTake)
      begin
        primary_reg <= 1'b1;
      end
      else if (riseTake && riseDbDone)
      begin
        primary_reg <= 1'b1;
      end
      if (!state_reg && fallDbDone && !riseTake)
      begin
        complementary_reg <= 1'b1;
      end
      else if (fallTake && fallDbDone)
      begin
        complementary_reg <= 1'b1;
      end
    end
  end

  assign primaryOut       = primary_reg;
  assign complementaryOut = complementary_reg;

endmodule
